// File: inc/tpr_pkg.sv
// Constants, states and carriers of the ternary receive coding block.
// Assumes one 250 MHz clock and symbols from same-clock line logic.
package tpr_pkg;

   // Ternary symbol codes on the input
   localparam logic [1:0] TPR_SYM_ZERO = 2'h0;
   localparam logic [1:0] TPR_SYM_PLUS = 2'h1;
   localparam logic [1:0] TPR_SYM_MINUS = 2'h3;

   // Consecutive idle pairs needed to lock during training
   localparam logic [6:0] TPR_LOCK_PAIRS = 7'h40;
   // Delimiter pair counts
   localparam logic [1:0] TPR_DELIM_PAIRS = 2'h3;
   localparam logic [1:0] TPR_CNT_ONE = 2'h1;
   // Nibble assembly
   localparam logic [2:0] TPR_NIBBLE_BITS = 3'h4;
   localparam logic [2:0] TPR_GROUP_BITS = 3'h3;

   // Reset values
   localparam logic [3:0] TPR_RXD_RESET = 4'h0;
   localparam logic [6:0] TPR_ACC_RESET = 7'h00;

   // Receive states, Gray along train, idle, start, data, end
   typedef enum logic [2:0] {
      TPR_ST_TRAIN = 3'b000,
      TPR_ST_IDLE = 3'b001,
      TPR_ST_SSD = 3'b011,
      TPR_ST_DATA = 3'b010,
      TPR_ST_ESD = 3'b110
   } tpr_state_t;

   // One ternary symbol from the line
   typedef struct packed {
      logic valid;
      logic [1:0] sym;
   } tpr_sym_t;

   // One corrected pair (A, B)
   typedef struct packed {
      logic [1:0] a;
      logic [1:0] b;
   } tpr_pair_t;

   // MII receive side
   typedef struct packed {
      logic [3:0] rxd;
      logic rx_dv;
      logic rx_er;
      logic rxd_strobe;
   } tpr_mii_t;

   // Management indications
   typedef struct packed {
      logic link_up;
      logic idle_rx;
      logic pol_inverted;
      logic order_swapped;
      logic leader;
   } tpr_status_t;

endpackage

// File: rtl/tpr_receive.sv
// Receive coding sublayer: ternary pairs to MII nibbles.
// Assumes symbols arrive one per valid cycle from same-clock line logic.
//
// Notes on behaviour
// RQ1 - Decode training, idle and frame data
// RQ2 - Works as leader or follower
// RQ3 - Idle pattern lock brings link up
// RQ4 - Report link, deliver frames to MII
// RQ5 - Idle only: flag idle, keep link
// RQ6 - Detect inverted polarity without configuration
// RQ7 - Inverted pair still links and receives
// RQ8 - Three zero pairs start a frame
// RQ9 - Zero, zero, plus-plus ends frame cleanly
// RQ10 - Error end pair raises receive error
// RQ11 - Drop leftover stuff bits at frame end
// RQ12 - De-interleave pairs in either order
// RQ13 - Nibbles out with rx_dv over frame
`timescale 1ns/1ps

module tpr_receive (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic leader_role,
   input wire tpr_pkg::tpr_sym_t rx_sym,
   output tpr_pkg::tpr_mii_t mii_rx,
   output tpr_pkg::tpr_status_t link_status
);

   ////////////////////////////////////////////////////////////////////////
   // Helper functions

   // Negate a ternary symbol
   function automatic logic [1:0] tpr_neg(input logic [1:0] s);
      tpr_neg = (s == tpr_pkg::TPR_SYM_ZERO) ? tpr_pkg::TPR_SYM_ZERO :
                ((s == tpr_pkg::TPR_SYM_PLUS) ? tpr_pkg::TPR_SYM_MINUS : tpr_pkg::TPR_SYM_PLUS);
   endfunction

   // Map a pair to a 3-bit group; bit 3 marks a data pair
   function automatic logic [3:0] tpr_pair_bits(input tpr_pkg::tpr_pair_t p);
      logic [1:0] ia;
      logic [1:0] ib;
      ia = (p.a == tpr_pkg::TPR_SYM_MINUS) ? 2'h0 : ((p.a == tpr_pkg::TPR_SYM_ZERO) ? 2'h1 : 2'h2);
      ib = (p.b == tpr_pkg::TPR_SYM_MINUS) ? 2'h0 : ((p.b == tpr_pkg::TPR_SYM_ZERO) ? 2'h1 : 2'h2);
      unique case ({ia, ib})
         4'h0: tpr_pair_bits = 4'h8;
         4'h1: tpr_pair_bits = 4'h9;
         4'h2: tpr_pair_bits = 4'hA;
         4'h4: tpr_pair_bits = 4'hB;
         4'h6: tpr_pair_bits = 4'hC;
         4'h8: tpr_pair_bits = 4'hD;
         4'h9: tpr_pair_bits = 4'hE;
         4'hA: tpr_pair_bits = 4'hF;
         default: tpr_pair_bits = 4'h0;
      endcase
   endfunction

   // Pair equality
   function automatic logic tpr_is(input tpr_pkg::tpr_pair_t p, input logic [1:0] a, input logic [1:0] b);
      tpr_is = (p.a == a) && (p.b == b);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // State

   tpr_pkg::tpr_state_t state;
   tpr_pkg::tpr_state_t next_state;
   logic phase;
   logic next_phase;
   logic [1:0] first_sym;
   logic [1:0] next_first_sym;
   logic [6:0] lock_cnt;
   logic [6:0] next_lock_cnt;
   logic [1:0] lock_cand;
   logic [1:0] next_lock_cand;
   logic [1:0] delim_cnt;
   logic [1:0] next_delim_cnt;
   logic [6:0] acc;
   logic [6:0] next_acc;
   logic [2:0] acc_cnt;
   logic [2:0] next_acc_cnt;
   tpr_pkg::tpr_mii_t next_mii_rx;
   tpr_pkg::tpr_status_t next_link_status;

   // Pair assembly and correction
   tpr_pkg::tpr_pair_t raw_pair;
   tpr_pkg::tpr_pair_t cor_pair;
   logic pair_done;
   logic [1:0] cand;
   logic cand_ok;
   logic [3:0] grp;
   logic [9:0] acc_wide;
   logic [2:0] acc_sum;

   ////////////////////////////////////////////////////////////////////////
   // Pair forming and idle classification
   always_comb begin
      pair_done = rx_sym.valid && phase;
      raw_pair.a = first_sym;
      raw_pair.b = rx_sym.sym;
      // RQ12 - swap pair order
      cor_pair = link_status.order_swapped ? {raw_pair.b, raw_pair.a} : raw_pair;
      // RQ7 - undo inverted pair
      if (link_status.pol_inverted) begin
         cor_pair.a = tpr_neg(cor_pair.a);
         cor_pair.b = tpr_neg(cor_pair.b);
      end
      // RQ6 - classify idle as order and polarity
      cand_ok = 1'b1;
      if (tpr_is(raw_pair, tpr_pkg::TPR_SYM_ZERO, tpr_pkg::TPR_SYM_PLUS)) begin
         cand = 2'h0;
      end else if (tpr_is(raw_pair, tpr_pkg::TPR_SYM_ZERO, tpr_pkg::TPR_SYM_MINUS)) begin
         cand = 2'h1;
      end else if (tpr_is(raw_pair, tpr_pkg::TPR_SYM_PLUS, tpr_pkg::TPR_SYM_ZERO)) begin
         cand = 2'h2;
      end else if (tpr_is(raw_pair, tpr_pkg::TPR_SYM_MINUS, tpr_pkg::TPR_SYM_ZERO)) begin
         cand = 2'h3;
      end else begin
         cand = 2'h0;
         cand_ok = 1'b0;
      end
      grp = tpr_pair_bits(cor_pair);
   end

   ////////////////////////////////////////////////////////////////////////
   // Next-state logic
   always_comb begin
      next_state = state;
      next_phase = phase;
      next_first_sym = first_sym;
      next_lock_cnt = lock_cnt;
      next_lock_cand = lock_cand;
      next_delim_cnt = delim_cnt;
      next_acc = acc;
      next_acc_cnt = acc_cnt;
      next_mii_rx = mii_rx;
      next_mii_rx.rx_er = 1'b0;
      next_mii_rx.rxd_strobe = 1'b0;
      next_link_status = link_status;
      // RQ2 - role only reported
      next_link_status.leader = leader_role;
      acc_wide = {3'h0, acc} | ({7'h00, grp[2:0]} << acc_cnt);
      acc_sum = acc_cnt + tpr_pkg::TPR_GROUP_BITS;
      if (rx_sym.valid) begin
         next_phase = ~phase;
         if (!phase) begin
            next_first_sym = rx_sym.sym;
         end
      end
      if (pair_done) begin
         unique case (state)
            tpr_pkg::TPR_ST_TRAIN: begin
               // RQ3 - count matching idle pairs
               if (!cand_ok) begin
                  next_lock_cnt = 7'h00;
               end else if (lock_cnt == 7'h00 || cand != lock_cand) begin
                  next_lock_cand = cand;
                  next_lock_cnt = 7'h01;
               end else if (lock_cnt + 7'h01 == tpr_pkg::TPR_LOCK_PAIRS) begin
                  next_state = tpr_pkg::TPR_ST_IDLE;
                  next_lock_cnt = 7'h00;
                  // RQ4 - report link up
                  next_link_status.link_up = 1'b1;
                  next_link_status.idle_rx = 1'b1;
                  next_link_status.pol_inverted = lock_cand[0];
                  next_link_status.order_swapped = lock_cand[1];
               end else begin
                  next_lock_cnt = lock_cnt + 7'h01;
               end
            end
            tpr_pkg::TPR_ST_IDLE: begin
               // RQ5 - idle keeps link and flag
               if (tpr_is(cor_pair, tpr_pkg::TPR_SYM_ZERO, tpr_pkg::TPR_SYM_PLUS)) begin
                  next_link_status.idle_rx = 1'b1;
               end else if (tpr_is(cor_pair, tpr_pkg::TPR_SYM_ZERO, tpr_pkg::TPR_SYM_ZERO)) begin
                  next_state = tpr_pkg::TPR_ST_SSD;
                  next_delim_cnt = tpr_pkg::TPR_CNT_ONE;
                  next_link_status.idle_rx = 1'b0;
               end else begin
                  next_state = tpr_pkg::TPR_ST_TRAIN;
                  next_link_status.link_up = 1'b0;
                  next_link_status.idle_rx = 1'b0;
               end
            end
            tpr_pkg::TPR_ST_SSD: begin
               // RQ8 - third zero pair opens frame
               if (!tpr_is(cor_pair, tpr_pkg::TPR_SYM_ZERO, tpr_pkg::TPR_SYM_ZERO)) begin
                  next_state = tpr_pkg::TPR_ST_IDLE;
               end else if (delim_cnt + tpr_pkg::TPR_CNT_ONE == tpr_pkg::TPR_DELIM_PAIRS) begin
                  next_state = tpr_pkg::TPR_ST_DATA;
                  next_acc = tpr_pkg::TPR_ACC_RESET;
                  next_acc_cnt = 3'h0;
                  next_mii_rx.rx_dv = 1'b1;
               end else begin
                  next_delim_cnt = delim_cnt + tpr_pkg::TPR_CNT_ONE;
               end
            end
            tpr_pkg::TPR_ST_DATA: begin
               if (tpr_is(cor_pair, tpr_pkg::TPR_SYM_ZERO, tpr_pkg::TPR_SYM_ZERO)) begin
                  next_state = tpr_pkg::TPR_ST_ESD;
                  next_delim_cnt = tpr_pkg::TPR_CNT_ONE;
               end else if (grp[3]) begin
                  // RQ1 - groups into nibbles
                  if (acc_sum >= tpr_pkg::TPR_NIBBLE_BITS) begin
                     // RQ13 - nibble out during frame
                     next_mii_rx.rxd = acc_wide[3:0];
                     next_mii_rx.rxd_strobe = 1'b1;
                     next_acc = {3'h0, acc_wide[7:4]};
                     next_acc_cnt = acc_sum - tpr_pkg::TPR_NIBBLE_BITS;
                  end else begin
                     next_acc = acc_wide[6:0];
                     next_acc_cnt = acc_sum;
                  end
               end else begin
                  next_mii_rx.rx_er = 1'b1;
               end
            end
            tpr_pkg::TPR_ST_ESD: begin
               // RQ11 - leftover bits are never sent
               next_acc = tpr_pkg::TPR_ACC_RESET;
               next_acc_cnt = 3'h0;
               if (delim_cnt == tpr_pkg::TPR_CNT_ONE) begin
                  if (tpr_is(cor_pair, tpr_pkg::TPR_SYM_ZERO, tpr_pkg::TPR_SYM_ZERO)) begin
                     next_delim_cnt = delim_cnt + tpr_pkg::TPR_CNT_ONE;
                  end else begin
                     next_mii_rx.rx_er = 1'b1;
                     next_mii_rx.rx_dv = 1'b0;
                     next_state = tpr_pkg::TPR_ST_IDLE;
                  end
               end else begin
                  // RQ9 - clean end closes frame
                  next_state = tpr_pkg::TPR_ST_IDLE;
                  next_mii_rx.rx_dv = 1'b0;
                  // RQ10 - error or bad third pair
                  if (!tpr_is(cor_pair, tpr_pkg::TPR_SYM_PLUS, tpr_pkg::TPR_SYM_PLUS)) begin
                     next_mii_rx.rx_er = 1'b1;
                  end
               end
            end
            default: begin
               next_state = tpr_pkg::TPR_ST_TRAIN;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers, frozen while clk_en is low
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state <= tpr_pkg::TPR_ST_TRAIN;
         phase <= 1'b0;
         first_sym <= tpr_pkg::TPR_SYM_ZERO;
         lock_cnt <= 7'h00;
         lock_cand <= 2'h0;
         delim_cnt <= 2'h0;
         acc <= tpr_pkg::TPR_ACC_RESET;
         acc_cnt <= 3'h0;
         mii_rx <= '{rxd: tpr_pkg::TPR_RXD_RESET, rx_dv: 1'b0, rx_er: 1'b0, rxd_strobe: 1'b0};
         link_status <= '{default: 1'b0};
      end else if (clk_en) begin
         state <= next_state;
         phase <= next_phase;
         first_sym <= next_first_sym;
         lock_cnt <= next_lock_cnt;
         lock_cand <= next_lock_cand;
         delim_cnt <= next_delim_cnt;
         acc <= next_acc;
         acc_cnt <= next_acc_cnt;
         mii_rx <= next_mii_rx;
         link_status <= next_link_status;
      end
   end

endmodule

// File: tb/tpr_partner.sv
// Link partner model: sends logical ternary pairs on the line.
// Assumes the bench sets order and polarity before training.
`timescale 1ns/1ps
module tpr_partner (
   input wire logic sys_clk,
   input wire logic swap,
   input wire logic inv,
   output tpr_pkg::tpr_sym_t rx_sym
);
   initial rx_sym = '0;
   function automatic logic [1:0] pol(input logic [1:0] s);
      if (inv && s != tpr_pkg::TPR_SYM_ZERO) begin
         return s ^ 2'h2;
      end
      return s;
   endfunction
   task automatic put(input logic [1:0] s);
      @(posedge sys_clk);
      rx_sym <= '{valid: 1'b1, sym: pol(s)};
   endtask
   task automatic send_pair(input logic [1:0] a, input logic [1:0] b);
      if (swap) begin
         put(b);
         put(a);
      end else begin
         put(a);
         put(b);
      end
   endtask
   // Line released: show a changed code
   task automatic stop;
      @(posedge sys_clk);
      rx_sym <= '{valid: 1'b0, sym: ~rx_sym.sym};
   endtask
endmodule

// File: tb/tpr_receive_monitor.sv
// Checker for the ternary receive block, bound to its ports.
// Assumes one clock and an asynchronous active-high reset.
`timescale 1ns/1ps
module tpr_receive_monitor (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic leader_role,
   input wire tpr_pkg::tpr_sym_t rx_sym,
   input wire tpr_pkg::tpr_mii_t mii_rx,
   input wire tpr_pkg::tpr_status_t link_status
);
   logic ph;
   logic done_q;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   // Pair phase and marker of a pair taken last edge, held while frozen
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ph <= 1'b0;
         done_q <= 1'b0;
      end else begin
         if (clk_en) begin
            done_q <= rx_sym.valid & ph;
         end
         if (clk_en & rx_sym.valid) begin
            ph <= ~ph;
         end
      end
   end
   ////////////////////////////////////////////////////////////////
   // Output relations
   strobe_in_frame_a: assert property (mii_rx.rxd_strobe |-> mii_rx.rx_dv)
      else $error("nibble strobe outside frame");
   strobe_on_pair_a: assert property (mii_rx.rxd_strobe |-> done_q)
      else $error("nibble strobe without pair");
   error_on_pair_a: assert property (mii_rx.rx_er |-> done_q ##1 !mii_rx.rx_er)
      else $error("error flag not a pair pulse");
   dv_on_pair_a: assert property (!$stable(mii_rx.rx_dv) |-> done_q)
      else $error("frame valid moved without pair");
   link_on_pair_a: assert property (!$stable({link_status.link_up, link_status.idle_rx}) |-> done_q)
      else $error("link state moved without pair");
   idle_needs_link_a: assert property (link_status.idle_rx |-> link_status.link_up && !mii_rx.rx_dv)
      else $error("idle flag without link or in frame");
   frame_needs_link_a: assert property (mii_rx.rx_dv |-> link_status.link_up)
      else $error("frame valid without link");
   rxd_hold_a: assert property (!mii_rx.rxd_strobe |-> mii_rx.rxd == $past(mii_rx.rxd))
      else $error("nibble changed without strobe");
endmodule
bind tpr_receive tpr_receive_monitor tpr_receive_monitor_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
   .clk_en(clk_en), .leader_role(leader_role), .rx_sym(rx_sym), .mii_rx(mii_rx), .link_status(link_status));

// File: tb/tpr_receive_test.sv
// Self-checking bench of the ternary receive block.
// Assumes the partner model drives the symbol stream.
`timescale 1ns/1ps
module tpr_receive_test;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic clk_en = 1'b1;
   logic leader_role = 1'b0;
   logic swap = 1'b0;
   logic inv = 1'b0;
   tpr_pkg::tpr_sym_t rx_sym;
   tpr_pkg::tpr_mii_t mii_rx;
   tpr_pkg::tpr_status_t link_status;
   int n_mismatch = 0;
   int compares = 0;
   logic [3:0] got[$];
   localparam logic [1:0] Z = tpr_pkg::TPR_SYM_ZERO;
   localparam logic [1:0] P = tpr_pkg::TPR_SYM_PLUS;
   localparam logic [1:0] M = tpr_pkg::TPR_SYM_MINUS;
   always #2 sys_clk = ~sys_clk;
   tpr_receive tpr_receive_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en),
      .leader_role(leader_role), .rx_sym(rx_sym), .mii_rx(mii_rx), .link_status(link_status));
   tpr_partner tpr_partner_inst (.sys_clk(sys_clk), .swap(swap), .inv(inv), .rx_sym(rx_sym));
   // Nibble capture
   always @(posedge sys_clk) begin
      if (mii_rx.rxd_strobe === 1'b1) begin
         got.push_back(mii_rx.rxd);
      end
   end
   ////////////////////////////////////////////////////////////////
   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic report_and_stop;
      $display("compares %0d n_mismatch %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic settle;
      tpr_partner_inst.stop();
      #1;
   endtask
   function automatic logic [15:0] up_stat();
      return 16'({1'b1, 1'b1, inv, swap, leader_role});
   endfunction
   // Three-bit group to logical pair
   function automatic logic [3:0] gpair(input logic [2:0] g);
      logic [1:0] t[3];
      int i;
      t = '{M, Z, P};
      i = (g < 3'h4) ? int'(g) : int'(g) + 1;
      return {t[i / 3], t[i % 3]};
   endfunction
   task automatic do_reset(input logic [1:0] c);
      @(posedge sys_clk);
      sys_rst <= 1'b1;
      swap <= c[0];
      inv <= c[1];
      leader_role <= ^c;
      repeat (12) @(posedge sys_clk);
      chk("reset outputs", 16'({mii_rx, link_status}), 16'h0000);
      sys_rst <= 1'b0;
   endtask
   task automatic do_train;
      repeat (63) tpr_partner_inst.send_pair(Z, P);
      settle();
      chk("link before lock", 16'(link_status.link_up), 16'h0000);
      tpr_partner_inst.send_pair(Z, P);
      settle();
      chk("status at lock", 16'(link_status), up_stat());
   endtask
   task automatic do_frame(input int nb, input bit good);
      logic bq[$];
      logic [3:0] exp[$];
      logic [7:0] by;
      logic [3:0] pr;
      got.delete();
      for (int k = 0; k < nb; k++) begin
         by = 8'(8'h3C + k * 8'h47);
         exp.push_back(by[3:0]);
         exp.push_back(by[7:4]);
         for (int j = 0; j < 8; j++) bq.push_back(by[j]);
      end
      while (bq.size() % 3 != 0) bq.push_back(1'b0);
      repeat (3) tpr_partner_inst.send_pair(Z, Z);
      settle();
      chk("frame start", 16'({mii_rx.rx_dv, link_status.idle_rx}), 16'h0002);
      for (int i = 0; i < bq.size(); i += 3) begin
         pr = gpair({bq[i + 2], bq[i + 1], bq[i]});
         tpr_partner_inst.send_pair(pr[3:2], pr[1:0]);
      end
      repeat (2) tpr_partner_inst.send_pair(Z, Z);
      tpr_partner_inst.send_pair(good ? P : M, good ? P : M);
      settle();
      chk("end dv er", 16'({mii_rx.rx_dv, mii_rx.rx_er}), good ? 16'h0000 : 16'h0001);
      chk("nibble count", 16'(got.size()), 16'(2 * nb));
      for (int i = 0; i < got.size() && i < exp.size(); i++) chk("nibble", 16'(got[i]), 16'(exp[i]));
   endtask
   task automatic do_idle;
      repeat (20) tpr_partner_inst.send_pair(Z, P);
      settle();
      chk("status in idle", 16'(link_status), up_stat());
      // A link-breaking pair while frozen must be ignored
      clk_en <= 1'b0;
      tpr_partner_inst.send_pair(P, P);
      settle();
      clk_en <= 1'b1;
      chk("status when frozen", 16'(link_status), up_stat());
   endtask
   ////////////////////////////////////////////////////////////////
   // Main sequence over order, polarity and role
   initial begin
      for (int c = 0; c < 4; c++) begin
         do_reset(2'(c));
         do_train();
         do_frame(c + 1, 1'b1);
         do_idle();
         do_frame(c + 2, 1'b0);
         do_idle();
      end
      report_and_stop();
   end
   // Watchdog
   initial begin
      #100000;
      n_mismatch++;
      report_and_stop();
   end
endmodule
